// *** core/ivpm_pkg.sv ***
// Package of constants for the interrupt vector priority map
package ivpm_pkg;

  // Vector slot offsets
  localparam logic [7:0] IVPM_OFS_TRAP = 8'hf8;
  localparam logic [7:0] IVPM_OFS_SWI = 8'hf6;
  localparam logic [7:0] IVPM_OFS_XIRQ = 8'hf4;
  localparam logic [7:0] IVPM_OFS_IRQ = 8'hf2;
  localparam logic [7:0] IVPM_OFS_RTI = 8'hf0;
  localparam logic [7:0] IVPM_OFS_TCH0 = 8'hee;
  localparam logic [7:0] IVPM_OFS_TCH1 = 8'hec;
  localparam logic [7:0] IVPM_OFS_TCH2 = 8'hea;
  localparam logic [7:0] IVPM_OFS_TCH3 = 8'he8;
  localparam logic [7:0] IVPM_OFS_TOVF = 8'hde;
  localparam logic [7:0] IVPM_OFS_SPI = 8'hd8;
  localparam logic [7:0] IVPM_OFS_SCI0 = 8'hd6;
  localparam logic [7:0] IVPM_OFS_SCI1 = 8'hd4;
  localparam logic [7:0] IVPM_OFS_ADC = 8'hd2;
  localparam logic [7:0] IVPM_OFS_PORTL = 8'hce;
  localparam logic [7:0] IVPM_OFS_OSC = 8'hc8;
  localparam logic [7:0] IVPM_OFS_PLL = 8'hc6;
  localparam logic [7:0] IVPM_OFS_FERR = 8'hba;
  localparam logic [7:0] IVPM_OFS_FCMD = 8'hb8;
  localparam logic [7:0] IVPM_OFS_HSDRV = 8'hae;
  localparam logic [7:0] IVPM_OFS_LSDRV = 8'hac;
  localparam logic [7:0] IVPM_OFS_LIN = 8'haa;
  localparam logic [7:0] IVPM_OFS_BAT = 8'ha8;
  localparam logic [7:0] IVPM_OFS_PORTP = 8'h8e;
  localparam logic [7:0] IVPM_OFS_SUPOC = 8'h8c;
  localparam logic [7:0] IVPM_OFS_LVI = 8'h8a;
  localparam logic [7:0] IVPM_OFS_API = 8'h88;
  localparam logic [7:0] IVPM_OFS_HTEMP = 8'h86;
  localparam logic [7:0] IVPM_OFS_ACMP = 8'h84;
  localparam logic [7:0] IVPM_OFS_PORTAD = 8'h82;
  localparam logic [7:0] IVPM_OFS_SPUR = 8'h80;

  // Maskable source indices, highest priority first
  localparam int IVPM_NSRC = 25;
  localparam int IVPM_SRC_IRQ = 0;
  localparam int IVPM_SRC_RTI = 1;
  localparam int IVPM_SRC_TCH0 = 2;
  localparam int IVPM_SRC_TCH1 = 3;
  localparam int IVPM_SRC_TCH2 = 4;
  localparam int IVPM_SRC_TCH3 = 5;
  localparam int IVPM_SRC_TOVF = 6;
  localparam int IVPM_SRC_SPI = 7;
  localparam int IVPM_SRC_SCI0 = 8;
  localparam int IVPM_SRC_SCI1 = 9;
  localparam int IVPM_SRC_ADC = 10;
  localparam int IVPM_SRC_PORTL = 11;
  localparam int IVPM_SRC_OSC = 12;
  localparam int IVPM_SRC_PLL = 13;
  localparam int IVPM_SRC_FERR = 14;
  localparam int IVPM_SRC_FCMD = 15;
  localparam int IVPM_SRC_HSDRV = 16;
  localparam int IVPM_SRC_LSDRV = 17;
  localparam int IVPM_SRC_LIN = 18;
  localparam int IVPM_SRC_BAT = 19;
  localparam int IVPM_SRC_PORTP = 20;
  localparam int IVPM_SRC_SUPOC = 21;
  localparam int IVPM_SRC_LVI = 22;
  localparam int IVPM_SRC_API = 23;
  localparam int IVPM_SRC_HTEMP = 24;

  // Per-source wake abilities, bit index = source index
  localparam logic [24:0] IVPM_WAKE_STOP_MASK = 25'h0900801;
  localparam logic [24:0] IVPM_WAKE_WAIT_MASK = 25'h1ffbfff;

  // Reset values and configuration word count
  localparam logic [7:0] IVPM_VBASE_RST = 8'hff;
  localparam logic [7:0] IVPM_ZERO8 = 8'h00;
  localparam logic [2:0] IVPM_CFG_WORDS = 3'h4;
  localparam logic [2:0] IVPM_CFG_ZERO = 3'h0;

  typedef enum logic [1:0] {
    IVPM_CFG_LOAD,
    IVPM_CFG_RUN
  } ivpm_cfg_state_t;

endpackage

// *** core/ivpm_cfg_loader.sv ***
// Configuration load sequencer that stalls the core after every reset
`timescale 1ns/1ns
module ivpm_cfg_loader
  import ivpm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_word_valid_i,
  input wire logic cfg_double_fault_i,
  output logic cpu_stall_o,
  output logic secure_o
);

  ivpm_cfg_state_t state_reg;
  logic [2:0] count_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= IVPM_CFG_LOAD;
      count_reg <= IVPM_CFG_ZERO;
    end else begin
      case (state_reg)
        IVPM_CFG_LOAD: begin
          if (cfg_word_valid_i) begin
            if (count_reg == IVPM_CFG_WORDS - 3'h1) begin
              state_reg <= IVPM_CFG_RUN;
            end
            count_reg <= count_reg + 3'h1;
          end
        end
        default: begin
          state_reg <= IVPM_CFG_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_stall_o <= 1'b1;
    end else begin
      cpu_stall_o <= (state_reg == IVPM_CFG_LOAD) &&
                     !(cfg_word_valid_i && count_reg == IVPM_CFG_WORDS - 3'h1);
    end
  end

  // Secured on leaving reset when a double fault is seen during loading
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      secure_o <= 1'b0;
    end else if (state_reg == IVPM_CFG_LOAD && cfg_word_valid_i && cfg_double_fault_i) begin
      secure_o <= 1'b1;
    end
  end

endmodule

// *** core/ivpm_top.sv ***
// Interrupt vector priority map with reset effects
`timescale 1ns/1ns
// How it works
// - Each source has a fixed slot at base plus offset, priority falling from $F8 to $80.
// - A software-written vector base forms the upper byte of every vector address.
// - The LIN slot $AA is shared by over-current and dominant timeout, each locally enabled.
// - The battery slot $A8 joins low and high voltage events, wakes from wait only.
// - The periodic timer slot $88 is gated by its enable and the I bit and wakes stop and wait.
// - The supply over-current slot $8C is gated by its enable and wakes from wait only.
// - Every reset returns all registers and control bits to defined values.
// - After reset the core is stalled until the configuration load completes.
// - A double fault in the configuration load leaves reset with security on.
// - A reset during a flash program or erase aborts that command at once.
// - Reset leaves RAM contents untouched.
module ivpm_top
  import ivpm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic vbase_we_i,
  input wire logic [7:0] vbase_wdata_i,
  input wire logic i_mask_i,
  input wire logic x_mask_i,
  input wire logic trap_i,
  input wire logic swi_i,
  input wire logic xirq_i,
  input wire logic [IVPM_NSRC-1:0] src_req_i,
  input wire logic [IVPM_NSRC-1:0] src_en_i,
  input wire logic lin_overcurrent_i,
  input wire logic lin_dominant_timeout_i,
  input wire logic lin_overcurrent_int_en_i,
  input wire logic lin_dominant_timeout_int_en_i,
  input wire logic battery_low_i,
  input wire logic battery_high_i,
  input wire logic battery_low_int_en_i,
  input wire logic battery_high_int_en_i,
  input wire logic supply_overcurrent_i,
  input wire logic supply_overcurrent_int_en_i,
  input wire logic periodic_timer_i,
  input wire logic periodic_timer_int_en_i,
  input wire logic in_stop_i,
  input wire logic in_wait_i,
  input wire logic cfg_word_valid_i,
  input wire logic cfg_double_fault_i,
  input wire logic flash_cmd_start_i,
  input wire logic flash_cmd_done_i,
  input wire logic ram_we_i,
  input wire logic [3:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] vector_base_reg_o,
  output logic irq_pending_o,
  output logic [15:0] vector_addr_o,
  output logic wake_o,
  output logic cpu_stall_o,
  output logic secure_o,
  output logic flash_cmd_busy_o,
  output logic [7:0] ram_rdata_o
);

  // ----------------------------------------------------------------
  // Vector base
  // ----------------------------------------------------------------
  logic [7:0] vector_base_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vector_base_reg <= IVPM_VBASE_RST;
    end else if (vbase_we_i) begin
      vector_base_reg <= vbase_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vector_base_reg_o <= IVPM_VBASE_RST;
    end else if (vbase_we_i) begin
      vector_base_reg_o <= vbase_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Source gating
  // ----------------------------------------------------------------
  logic [IVPM_NSRC-1:0] req_raw;
  logic [IVPM_NSRC-1:0] req_en;
  logic [IVPM_NSRC-1:0] req_act;

  always_comb begin
    req_raw = src_req_i;
    req_en = src_en_i;
    req_raw[IVPM_SRC_LIN] = (lin_overcurrent_i && lin_overcurrent_int_en_i) ||
                            (lin_dominant_timeout_i && lin_dominant_timeout_int_en_i);
    req_en[IVPM_SRC_LIN] = 1'b1;
    req_raw[IVPM_SRC_BAT] = (battery_low_i && battery_low_int_en_i) ||
                            (battery_high_i && battery_high_int_en_i);
    req_en[IVPM_SRC_BAT] = 1'b1;
    req_raw[IVPM_SRC_SUPOC] = supply_overcurrent_i;
    req_en[IVPM_SRC_SUPOC] = supply_overcurrent_int_en_i;
    req_raw[IVPM_SRC_API] = periodic_timer_i;
    req_en[IVPM_SRC_API] = periodic_timer_int_en_i;
  end

  genvar g;
  generate
    for (g = 0; g < IVPM_NSRC; g++) begin : g_gate
      assign req_act[g] = req_raw[g] && req_en[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  logic [7:0] slot_ofs [IVPM_NSRC];
  assign slot_ofs = '{IVPM_OFS_IRQ, IVPM_OFS_RTI, IVPM_OFS_TCH0, IVPM_OFS_TCH1,
                      IVPM_OFS_TCH2, IVPM_OFS_TCH3, IVPM_OFS_TOVF, IVPM_OFS_SPI,
                      IVPM_OFS_SCI0, IVPM_OFS_SCI1, IVPM_OFS_ADC, IVPM_OFS_PORTL,
                      IVPM_OFS_OSC, IVPM_OFS_PLL, IVPM_OFS_FERR, IVPM_OFS_FCMD,
                      IVPM_OFS_HSDRV, IVPM_OFS_LSDRV, IVPM_OFS_LIN, IVPM_OFS_BAT,
                      IVPM_OFS_PORTP, IVPM_OFS_SUPOC, IVPM_OFS_LVI, IVPM_OFS_API,
                      IVPM_OFS_HTEMP};

  logic any_next;
  logic [7:0] ofs_next;

  always_comb begin
    any_next = 1'b1;
    ofs_next = IVPM_OFS_SPUR;
    if (trap_i) begin
      ofs_next = IVPM_OFS_TRAP;
    end else if (swi_i) begin
      ofs_next = IVPM_OFS_SWI;
    end else if (xirq_i && !x_mask_i) begin
      ofs_next = IVPM_OFS_XIRQ;
    end else if (!i_mask_i && (|req_act)) begin
      for (int i = IVPM_NSRC - 1; i >= 0; i--) begin
        if (req_act[i]) begin
          ofs_next = slot_ofs[i];
        end
      end
    end else begin
      any_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_pending_o <= 1'b0;
      vector_addr_o <= {IVPM_VBASE_RST, IVPM_OFS_SPUR};
    end else begin
      irq_pending_o <= any_next && !cpu_stall_o;
      vector_addr_o <= {vector_base_reg, ofs_next};
    end
  end

  // ----------------------------------------------------------------
  // Wake from stop or wait
  // ----------------------------------------------------------------
  logic wake_next;

  always_comb begin
    wake_next = xirq_i && !x_mask_i;
    if (!i_mask_i) begin
      if (in_stop_i) begin
        wake_next = wake_next || (|(req_act & IVPM_WAKE_STOP_MASK));
      end else if (in_wait_i) begin
        wake_next = wake_next || (|(req_act & IVPM_WAKE_WAIT_MASK));
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_next && (in_stop_i || in_wait_i);
    end
  end

  // ----------------------------------------------------------------
  // Configuration load and flash command
  // ----------------------------------------------------------------
  ivpm_cfg_loader u_cfg_loader (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .cfg_word_valid_i(cfg_word_valid_i),
    .cfg_double_fault_i(cfg_double_fault_i),
    .cpu_stall_o(cpu_stall_o),
    .secure_o(secure_o)
  );

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_cmd_busy_o <= 1'b0;
    end else if (flash_cmd_start_i) begin
      flash_cmd_busy_o <= 1'b1;
    end else if (flash_cmd_done_i) begin
      flash_cmd_busy_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // RAM, not cleared by reset
  // ----------------------------------------------------------------
  logic [7:0] ram_mem [16];

  always_ff @(posedge ref_clk_i) begin
    if (ram_we_i) begin
      ram_mem[ram_addr_i] <= ram_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_rdata_o <= IVPM_ZERO8;
    end else begin
      ram_rdata_o <= ram_mem[ram_addr_i];
    end
  end

endmodule

// *** testbench/ivpm_top_sva.sv ***
// Checker on the vector map top ports
`timescale 1ns/1ns
module ivpm_top_sva
  import ivpm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic vbase_we_i,
  input wire logic [7:0] vbase_wdata_i,
  input wire logic i_mask_i,
  input wire logic trap_i,
  input wire logic [IVPM_NSRC-1:0] src_req_i,
  input wire logic [IVPM_NSRC-1:0] src_en_i,
  input wire logic periodic_timer_i,
  input wire logic periodic_timer_int_en_i,
  input wire logic in_stop_i,
  input wire logic cfg_word_valid_i,
  input wire logic flash_cmd_start_i,
  input wire logic flash_cmd_done_i,
  input wire logic [7:0] vector_base_reg_o,
  input wire logic irq_pending_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic wake_o,
  input wire logic cpu_stall_o,
  input wire logic secure_o,
  input wire logic flash_cmd_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  base_load_a: assert property (vbase_we_i |=> vector_base_reg_o == $past(vbase_wdata_i))
    else $error("vector base not loaded");
  vec_base_a: assert property (!$past(vbase_we_i) |-> vector_addr_o[15:8] == vector_base_reg_o)
    else $error("vector high byte differs from base");
  trap_slot_a: assert property (trap_i |=> vector_addr_o[7:0] == IVPM_OFS_TRAP)
    else $error("trap did not win");
  stall_block_a: assert property (cpu_stall_o |-> !irq_pending_o)
    else $error("request taken while stalled");
  stall_drop_a: assert property ($fell(cpu_stall_o) |-> $past(cfg_word_valid_i))
    else $error("stall released without config word");
  secure_hold_a: assert property (secure_o |=> secure_o)
    else $error("secure flag dropped");
  busy_set_a: assert property (flash_cmd_start_i && !flash_cmd_done_i |=> flash_cmd_busy_o)
    else $error("flash busy not set");
  irq_take_a: assert property (src_req_i[0] && src_en_i[0] && !i_mask_i && !cpu_stall_o
    |=> irq_pending_o && vector_addr_o[7:0] != IVPM_OFS_SPUR)
    else $error("enabled request not presented");
  api_wake_a: assert property (periodic_timer_i && periodic_timer_int_en_i && !i_mask_i
    && in_stop_i |=> wake_o)
    else $error("timer did not wake from stop");
  cover property (vbase_we_i);
  cover property ($fell(cpu_stall_o));
  cover property (wake_o && in_stop_i);
endmodule
bind ivpm_top ivpm_top_sva chk (.*);

// *** testbench/ivpm_core_model.sv ***
// Core model latching fetched service addresses
`timescale 1ns/1ns
module ivpm_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cpu_stall_i,
  input wire logic irq_pending_i,
  input wire logic [15:0] vector_addr_i,
  output logic [15:0] fetch_addr_o
);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_addr_o <= 16'h0000;
    end else if (irq_pending_i && !cpu_stall_i) begin
      fetch_addr_o <= vector_addr_i;
    end
  end
endmodule

// *** testbench/interrupt_vector_priority_map_tb.sv ***
// Testbench for the vector map top
`timescale 1ns/1ns
module interrupt_vector_priority_map_tb;
  import ivpm_pkg::*;
  logic ref_clk_i, rst_b_i, vbase_we_i, i_mask_i, x_mask_i, trap_i, swi_i, xirq_i;
  logic [7:0] vbase_wdata_i, ram_wdata_i, vector_base_reg_o, ram_rdata_o, base;
  logic [IVPM_NSRC-1:0] src_req_i, src_en_i;
  logic lin_overcurrent_i, lin_dominant_timeout_i, lin_overcurrent_int_en_i;
  logic lin_dominant_timeout_int_en_i, battery_low_i, battery_high_i;
  logic battery_low_int_en_i, battery_high_int_en_i, supply_overcurrent_i;
  logic supply_overcurrent_int_en_i, periodic_timer_i, periodic_timer_int_en_i;
  logic in_stop_i, in_wait_i, cfg_word_valid_i, cfg_double_fault_i, ram_we_i;
  logic flash_cmd_start_i, flash_cmd_done_i, irq_pending_o, wake_o, cpu_stall_o;
  logic secure_o, flash_cmd_busy_o;
  logic [3:0] ram_addr_i;
  logic [15:0] vector_addr_o, fetch_addr;
  int failures, check_count;
  ivpm_top uut (.*);
  ivpm_core_model core (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cpu_stall_i(cpu_stall_o),
    .irq_pending_i(irq_pending_o), .vector_addr_i(vector_addr_o), .fetch_addr_o(fetch_addr));
  always #10 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic idle;
    {trap_i, swi_i, xirq_i, x_mask_i, i_mask_i, in_stop_i, in_wait_i} = 7'h00;
    {src_req_i, src_en_i} = '0;
    {lin_overcurrent_i, lin_dominant_timeout_i, battery_low_i, battery_high_i} = 4'h0;
    {supply_overcurrent_i, periodic_timer_i} = 2'h0;
    {lin_overcurrent_int_en_i, lin_dominant_timeout_int_en_i, battery_low_int_en_i} = 3'h7;
    {battery_high_int_en_i, supply_overcurrent_int_en_i, periodic_timer_int_en_i} = 3'h7;
  endtask
  task automatic load(input logic df);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i); #2;
      cfg_word_valid_i = 1'b1;
      cfg_double_fault_i = df & (i == 2);
      @(posedge ref_clk_i); #2;
      cfg_word_valid_i = 1'b0;
      cfg_double_fault_i = 1'b0;
      if (i < 3) chk("stall", cpu_stall_o, 1'b1);
      if (i < 3) chk("pending", irq_pending_o, 1'b0);
    end
    @(posedge ref_clk_i); #1;
    chk("stall", cpu_stall_o, 1'b0);
  endtask
  task automatic probe(input int k, input int stp, wt, input logic [7:0] ofs, input int wk);
    @(posedge ref_clk_i); #2;
    idle();
    in_stop_i = stp[0];
    in_wait_i = wt[0];
    case (k)
      0: lin_overcurrent_i = 1'b1;
      1: lin_dominant_timeout_i = 1'b1;
      2: battery_low_i = 1'b1;
      3: battery_high_i = 1'b1;
      4: supply_overcurrent_i = 1'b1;
      5: periodic_timer_i = 1'b1;
      6: {src_req_i[18], src_en_i[18]} = 2'h3;
      7: {trap_i, swi_i} = 2'h3;
      8: {swi_i, xirq_i} = 2'h3;
      9: xirq_i = 1'b1;
      10: {xirq_i, x_mask_i} = 2'h3;
      11: {src_req_i[1:0], src_en_i[1:0]} = 4'hf;
      12: {src_req_i[0], src_en_i[0], i_mask_i} = 3'h7;
      13: {lin_overcurrent_i, lin_overcurrent_int_en_i} = 2'h2;
      14: {periodic_timer_i, i_mask_i} = 2'h3;
    endcase
    @(posedge ref_clk_i); #1;
    chk("vector", vector_addr_o, {base, ofs});
    chk("pending", irq_pending_o, ofs != IVPM_OFS_SPUR);
    if (wk >= 0) chk("wake", wake_o, 16'(wk));
  endtask
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  initial begin
    {failures, check_count, ref_clk_i, rst_b_i, vbase_we_i, vbase_wdata_i} = '0;
    {cfg_word_valid_i, cfg_double_fault_i, flash_cmd_start_i, flash_cmd_done_i} = 4'h0;
    {ram_we_i, ram_addr_i, ram_wdata_i} = '0;
    idle();
    base = IVPM_VBASE_RST;
    repeat (16) @(posedge ref_clk_i);
    #1;
    chk("reset", {vector_base_reg_o, 7'h00, irq_pending_o}, 16'hff00);
    chk("vector", vector_addr_o, 16'hff80);
    chk("flags", {cpu_stall_o, secure_o, flash_cmd_busy_o, ram_rdata_o}, 16'h0400);
    #1 rst_b_i = 1'b1;
    {src_req_i[0], src_en_i[0]} = 2'h3;
    load(1'b1);
    chk("secure", secure_o, 1'b1);
    chk("irq", vector_addr_o, 16'hfff2);
    @(posedge ref_clk_i); #1;
    chk("fetch", fetch_addr, 16'hfff2);
    #1 {vbase_we_i, vbase_wdata_i} = 9'h13c;
    @(posedge ref_clk_i); #2;
    vbase_we_i = 1'b0;
    base = 8'h3c;
    chk("base", vector_base_reg_o, base);
    probe(0, 1, 0, IVPM_OFS_LIN, 0);
    probe(1, 0, 1, IVPM_OFS_LIN, 1);
    probe(13, 0, 1, IVPM_OFS_SPUR, -1);
    probe(2, 1, 0, IVPM_OFS_BAT, 0);
    probe(3, 0, 1, IVPM_OFS_BAT, 1);
    probe(4, 1, 0, IVPM_OFS_SUPOC, 0);
    probe(4, 0, 1, IVPM_OFS_SUPOC, 1);
    probe(5, 1, 0, IVPM_OFS_API, 1);
    probe(14, 1, 0, IVPM_OFS_SPUR, 0);
    probe(6, 0, 0, IVPM_OFS_SPUR, -1);
    probe(7, 0, 0, IVPM_OFS_TRAP, -1);
    probe(8, 0, 0, IVPM_OFS_SWI, -1);
    probe(9, 0, 0, IVPM_OFS_XIRQ, -1);
    probe(10, 0, 0, IVPM_OFS_SPUR, -1);
    probe(11, 0, 0, IVPM_OFS_IRQ, -1);
    probe(12, 0, 0, IVPM_OFS_SPUR, -1);
    #1;
    ram_we_i = 1'b1;
    ram_addr_i = 4'h2;
    ram_wdata_i = 8'ha5;
    flash_cmd_start_i = 1'b1;
    idle();
    @(posedge ref_clk_i); #2;
    {ram_we_i, flash_cmd_start_i} = 2'h0;
    chk("busy", flash_cmd_busy_o, 1'b1);
    rst_b_i = 1'b0;
    #1;
    chk("abort", flash_cmd_busy_o, 1'b0);
    chk("base", vector_base_reg_o, IVPM_VBASE_RST);
    @(posedge ref_clk_i); #2;
    rst_b_i = 1'b1;
    load(1'b0);
    chk("ram", ram_rdata_o, 8'ha5);
    chk("secure", secure_o, 1'b0);
    finish_test();
  end
endmodule
